// ===== verif/csf_core_tb.sv
/*
  Self-checking bench for csf_core: flag decisions, option decode, cycle
  counting and low-temperature inhibit, all reached over classic Wishbone.
  Assumes the register map and one-cycle ack latency of the csf_pkg block.
*/
`timescale 1ns/1ps
module csf_core_tb
  import csf_pkg::*;
;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic        clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0]  wb_adr_i = 8'h00, pct_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, seed = 32'h0000_749F, r;
  logic        wb_ack_o, meas_i = 1'h0, dsg_start_i = 1'h0, term_i = 1'h0;
  logic [15:0] volt_i = 16'h0000, temp_i = 16'h00FA, cur_i = 16'h0000, delta_i = 16'h0000;
  logic [15:0] fcap_i = 16'h1000, lcap_i = 16'h0000, stored_i = 16'h0007;
  logic        full_o, empty_o, inh_o, vdq_o, eod_o, comp_o, fixlo_o, chg_o, smo_o, skip_o;
  logic [15:0] thr0_o, thr1_o, thr2_o, lcap_o, count_o;
  logic        sync_o, store_o;
  logic [31:0] exp_q[$], msk_q[$];
  int          fails = 0, check_count = 0, cycles = 0, stores = 0;
  // Flag table: enable byte, percent, voltage, expected {empty, full}.
  logic [7:0]  t_cfg[14] = '{8'h40, 8'h40, 8'h80, 8'h80, 8'h10, 8'h10, 8'h20,
                             8'h04, 8'h04, 8'h08, 8'h01, 8'h02, 8'h02, 8'h00};
  logic [7:0]  t_pct[14] = '{8'h59, 8'h5A, 8'h1F, 8'h1E, 8'h23, 8'h23, 8'h23,
                             8'h0B, 8'h0A, 8'h28, 8'h23, 8'h23, 8'h23, 8'h5A};
  logic [15:0] t_v[14]   = '{16'h0980, 16'h0980, 16'h0980, 16'h0980, 16'h0FFF, 16'h1000,
                             16'h0900, 16'h0980, 16'h0980, 16'h0980, 16'h0800, 16'h09FF,
                             16'h0A00, 16'h1000};
  logic [1:0]  t_exp[14] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h0, 2'h1, 2'h0,
                             2'h0, 2'h2, 2'h0, 2'h2, 2'h2, 2'h0, 2'h0};

  csf_core uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .meas_valid_i(meas_i),
    .relative_charge_pct_i(pct_i), .voltage_i(volt_i), .temperature_i(temp_i),
    .dsg_current_i(cur_i), .dsg_delta_i(delta_i), .full_cap_i(fcap_i),
    .learned_cap_i(lcap_i), .dsg_start_i(dsg_start_i), .charge_term_i(term_i),
    .stored_cycle_i(stored_i), .full_charged_flag_o(full_o),
    .fully_discharged_flag_o(empty_o), .charge_inhibit_flag_o(inh_o),
    .valid_discharge_qual_o(vdq_o), .eod_detect_en_o(eod_o),
    .threshold_comp_sel_o(comp_o), .fixed_lowest_threshold_sel_o(fixlo_o),
    .charger_type_sel_o(chg_o), .smoothing_mode_bit_o(smo_o),
    .skip_self_discharge_o(skip_o), .end_discharge_thr_zero_o(thr0_o),
    .end_discharge_thr_one_o(thr1_o), .end_discharge_thr_two_o(thr2_o),
    .learned_cap_o(lcap_o), .remaining_sync_o(sync_o), .cycle_count_o(count_o),
    .cycle_store_o(store_o));

  // ==========================================================
  // Clock, timeout and result watchers.
  initial forever #12.5 clk_i = ~clk_i;
  // A hang is cut short well after the longest path through the tests.
  always @(posedge clk_i) begin
    cycles++;
    if (store_o === 1'h1) stores++;
    if (cycles == 20000) begin
      fails++;
      $display("mismatch at %0t: timeout", $time);
      end_of_test();
    end
  end
  // Read data is taken only at the ack edge, while the master still holds we low.
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'h1 && wb_we_i === 1'h0) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("mismatch at %0t: read with no expectation", $time);
      end else check_word(wb_dat_o, exp_q.pop_front(), msk_q.pop_front());
    end
  end

  // ==========================================================
  // Shared tasks.
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check_word(input logic [31:0] got, exp, msk);
    check_count++;
    if ((got & msk) !== (exp & msk)) begin
      fails++;
      $display("mismatch at %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_out(input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: output %h expected %h", $time, got, exp);
    end
  endtask
  // The request is held until ack is sampled high, then released for a cycle.
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [3:0] s,
                         input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'h1);
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_xfer(1'h1, a, 4'hF, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    wb_xfer(1'h0, a, 4'hF, 32'h0000_0000);
  endtask
  task automatic meas(input logic [7:0] p, input logic [15:0] v, t);
    @(posedge clk_i);
    meas_i <= 1'h1;
    pct_i <= p;
    volt_i <= v;
    temp_i <= t;
    @(posedge clk_i);
    meas_i <= 1'h0;
  endtask
  task automatic feed(input logic [15:0] d, input int n);
    @(posedge clk_i);
    delta_i <= d;
    repeat (n) @(posedge clk_i);
    delta_i <= 16'h0000;
  endtask
  task automatic start();
    @(posedge clk_i);
    dsg_start_i <= 1'h1;
    @(posedge clk_i);
    dsg_start_i <= 1'h0;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // Main sequence.
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    rd(OFS_FLAG_CFG, 32'h0000_008C, ALL);
    rd(OFS_TEMP_CFG, 32'h0032_0000, ALL);
    rd(OFS_CYCLE_CNT, 32'h0000_0007, ALL);
    wr(8'h40, ALL);
    rd(8'h40, 32'h0000_0000, ALL);
    wb_xfer(1'h1, OFS_FLAG_CFG, 4'h2, 32'h0000_FF00);
    rd(OFS_FLAG_CFG, 32'h0000_008C, ALL);
    #1 check_out(16'(comp_o), 16'h0001);
    check_out(16'(fixlo_o), 16'h0001);
    check_out(16'(chg_o), 16'h0000);
    $display("test reset_and_access done");
    // Thresholds sit so that a neutral sample of 35 percent, 0980 meets none.
    wr(OFS_PCT_THR, 32'h280A_1E5A);
    wr(OFS_VFULL_THR, 32'h0900_1000);
    wr(OFS_VEMPTY_THR, 32'h0A00_0800);
    for (int i = 0; i < 14; i++) begin
      wb_xfer(1'h1, OFS_FLAG_CFG, 4'h1, {24'h00_0000, t_cfg[i]});
      meas(t_pct[i], t_v[i], 16'h00FA);
      rd(OFS_STATUS, {30'h0, t_exp[i]}, 32'h0000_0003);
    end
    $display("test flag_table done");
    // Inhibit sets below 0.0 degC and releases only above 5.0 degC.
    meas(8'h23, 16'h0980, 16'hFFFF);
    rd(OFS_STATUS, 32'h0000_0004, 32'h0000_0004);
    meas(8'h23, 16'h0980, 16'h0032);
    rd(OFS_STATUS, 32'h0000_0004, 32'h0000_0004);
    meas(8'h23, 16'h0980, 16'h0033);
    rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0004);
    meas(8'h23, 16'h0980, 16'h0000);
    rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0004);
    $display("test inhibit done");
    // Learning opens only when warm, closes on a cold sample, and needs full if asked.
    meas(8'h23, 16'h0980, 16'h00FA);
    start();
    rd(OFS_STATUS, 32'h0000_0008, 32'h0000_0008);
    meas(8'h23, 16'h0980, 16'h0000);
    rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0008);
    wr(OFS_GAUGE_CFG, 32'h0000_0400);
    meas(8'h23, 16'h0980, 16'h00FA);
    start();
    rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0008);
    $display("test learning done");
    wr(OFS_GAUGE_CFG, ALL);
    rd(OFS_GAUGE_CFG, {16'h0000, GAUGE_CFG_MASK}, ALL);
    @(posedge clk_i);
    term_i <= 1'h1;
    lcap_i <= 16'h0200;
    #1 check_out(16'(sync_o), 16'h0001);
    check_out(16'({comp_o, fixlo_o, chg_o, smo_o, skip_o}), 16'h001F);
    wr(OFS_CYCLE_CFG, 32'h0100_000A);
    wr(OFS_CAP_CFG, 32'h0100_0000);
    #1 check_out(lcap_o, 16'h0100);
    wr(OFS_GAUGE_CFG, 32'h0000_0000);
    #1 check_out(16'(sync_o), 16'h0000);
    check_out(16'({comp_o, fixlo_o, chg_o}), 16'h0000);
    for (int i = 0; i < 6; i++) begin
      r = xs();
      @(posedge clk_i);
      lcap_i <= r[15:0];
      term_i <= 1'h0;
      wr(OFS_FIXED_01, r);
      wr(OFS_FIXED_2, {16'h0000, r[31:16]});
      #1 check_out(lcap_o, r[15:0]);
      check_out(thr0_o, r[15:0]);
      check_out(thr1_o, r[31:16]);
      check_out(thr2_o, r[31:16]);
    end
    wr(OFS_CAP_CFG, 32'h0500_0000);
    @(posedge clk_i);
    cur_i <= 16'h0500;
    #1 check_out(16'(eod_o), 16'h0001);
    @(posedge clk_i);
    cur_i <= 16'h0501;
    #1 check_out(16'(eod_o), 16'h0000);
    $display("test options done");
    // Design basis gives 128 per cycle, so the 256 floor must win.
    feed(16'h0010, 15);
    rd(OFS_CYCLE_CNT, 32'h0000_0007, ALL);
    feed(16'h0010, 1);
    rd(OFS_CYCLE_CNT, 32'h0000_0008, ALL);
    wr(OFS_GAUGE_CFG, 32'h0000_0001);
    feed(16'h0010, 16);
    rd(OFS_CYCLE_CNT, 32'h0000_0008, ALL);
    feed(16'h0099, 1);
    rd(OFS_CYCLE_CNT, 32'h0000_0009, ALL);
    repeat (3) @(posedge clk_i);
    check_out(16'(stores), 16'h0002);
    check_out(16'(exp_q.size()), 16'h0000);
    $display("test cycle_count done");
    end_of_test();
  end
endmodule

// ===== verilog/csf_core.sv
/*
  Charge-state flag decisions, gauging option decode, cycle counting and
  low-temperature charge inhibit, with a classic Wishbone register slave.
  Assumes measurements arrive synchronous to clk_i; a new sample is
  flagged by meas_valid_i, and discharge charge as dsg_delta_i pulses.
*/
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/1ps
module csf_core
  import csf_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        meas_valid_i,
  input  wire logic [7:0]  relative_charge_pct_i,
  input  wire logic [15:0] voltage_i,
  input  wire logic [15:0] temperature_i,
  input  wire logic [15:0] dsg_current_i,
  input  wire logic [15:0] dsg_delta_i,
  input  wire logic [15:0] full_cap_i,
  input  wire logic [15:0] learned_cap_i,
  input  wire logic        dsg_start_i,
  input  wire logic        charge_term_i,
  input  wire logic [15:0] stored_cycle_i,
  output logic             full_charged_flag_o,
  output logic             fully_discharged_flag_o,
  output logic             charge_inhibit_flag_o,
  output logic             valid_discharge_qual_o,
  output logic             eod_detect_en_o,
  output logic             threshold_comp_sel_o,
  output logic             fixed_lowest_threshold_sel_o,
  output logic             charger_type_sel_o,
  output logic             smoothing_mode_bit_o,
  output logic             skip_self_discharge_o,
  output logic [15:0]      end_discharge_thr_zero_o,
  output logic [15:0]      end_discharge_thr_one_o,
  output logic [15:0]      end_discharge_thr_two_o,
  output logic [15:0]      learned_cap_o,
  output logic             remaining_sync_o,
  output logic [15:0]      cycle_count_o,
  output logic             cycle_store_o
);
  // ==========================================================
  // Register file.
  logic [7:0]  flag_cfg_q;
  logic [15:0] gauge_cfg_q;
  logic [31:0] pct_thr_q, vfull_q, vempty_q, fixed01_q, temp_cfg_q, cap_cfg_q, cyc_cfg_q;
  logic [15:0] fixed2_q;
  logic        full_q, empty_q, inh_q, vdq_q, ack_q;
  logic [15:0] cyc_cnt_q;
  logic [31:0] dsg_acc_q;
  logic        init_q;

  // Merges written byte lanes into an old register word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // A write lands at the edge at which the master samples ack, so a
  // request withdrawn before its answer never changes a register.
  logic wr_req;
  assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;

  // The slave answers one cycle after the request and drops ack the next cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
    end
  end
  assign wb_ack_o = ack_q;

  // Register writes; a byte lane whose select is low keeps its old value.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_cfg_q  <= FLAG_CFG_RST;
      gauge_cfg_q <= GAUGE_CFG_RST;
      pct_thr_q   <= {EMPTY_CLR_PCT_RST, EMPTY_SET_PCT_RST, FULL_CLR_PCT_RST, FULL_SET_PCT_RST};
      vfull_q     <= {VOLT_RST, VOLT_RST};
      vempty_q    <= {VOLT_RST, VOLT_RST};
      fixed01_q   <= {VOLT_RST, VOLT_RST};
      fixed2_q    <= VOLT_RST;
      temp_cfg_q  <= {TEMP_HYS_RST, INH_LOW_TEMP_RST};
      cap_cfg_q   <= {OVERLOAD_RST, LEARN_TEMP_RST};
      cyc_cfg_q   <= {CYCLE_MIN_RST, CYCLE_PCT_RST};
    end else if (wr_req) begin
      case (wb_adr_i)
        OFS_FLAG_CFG:   flag_cfg_q  <= wb_sel_i[0] ? wb_dat_i[7:0] : flag_cfg_q;
        OFS_GAUGE_CFG:  gauge_cfg_q <= 16'(merge({16'h0000, gauge_cfg_q}, wb_dat_i, wb_sel_i))
                                       & GAUGE_CFG_MASK;
        OFS_PCT_THR:    pct_thr_q   <= merge(pct_thr_q, wb_dat_i, wb_sel_i);
        OFS_VFULL_THR:  vfull_q     <= merge(vfull_q, wb_dat_i, wb_sel_i);
        OFS_VEMPTY_THR: vempty_q    <= merge(vempty_q, wb_dat_i, wb_sel_i);
        OFS_FIXED_01:   fixed01_q   <= merge(fixed01_q, wb_dat_i, wb_sel_i);
        OFS_FIXED_2:    fixed2_q    <= 16'(merge({16'h0000, fixed2_q}, wb_dat_i, wb_sel_i));
        OFS_TEMP_CFG:   temp_cfg_q  <= merge(temp_cfg_q, wb_dat_i, wb_sel_i);
        OFS_CAP_CFG:    cap_cfg_q   <= merge(cap_cfg_q, wb_dat_i, wb_sel_i);
        OFS_CYCLE_CFG:  cyc_cfg_q   <= merge(cyc_cfg_q, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // Read data is registered; unmapped addresses read as zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      case (wb_adr_i)
        OFS_FLAG_CFG:   wb_dat_o <= {24'h000000, flag_cfg_q};
        OFS_GAUGE_CFG:  wb_dat_o <= {16'h0000, gauge_cfg_q};
        OFS_PCT_THR:    wb_dat_o <= pct_thr_q;
        OFS_VFULL_THR:  wb_dat_o <= vfull_q;
        OFS_VEMPTY_THR: wb_dat_o <= vempty_q;
        OFS_FIXED_01:   wb_dat_o <= fixed01_q;
        OFS_FIXED_2:    wb_dat_o <= {16'h0000, fixed2_q};
        OFS_TEMP_CFG:   wb_dat_o <= temp_cfg_q;
        OFS_CAP_CFG:    wb_dat_o <= cap_cfg_q;
        OFS_CYCLE_CFG:  wb_dat_o <= cyc_cfg_q;
        OFS_STATUS:     wb_dat_o <= {28'h0000000, vdq_q, inh_q, empty_q, full_q};
        OFS_CYCLE_CNT:  wb_dat_o <= {16'h0000, cyc_cnt_q};
        default:        wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Flag decisions, taken on each measurement sample.
  // All compares are unsigned; percent and voltage never go negative.
  logic full_set, full_clr, empty_set, empty_clr;
  always_comb begin
    full_set  = (flag_cfg_q[B_FULL_SET_PCT] && relative_charge_pct_i >= pct_thr_q[7:0])
             || (flag_cfg_q[B_FULL_SET_V] && voltage_i >= vfull_q[15:0]);
    full_clr  = (flag_cfg_q[B_FULL_CLR_PCT] && relative_charge_pct_i <= pct_thr_q[15:8])
             || (flag_cfg_q[B_FULL_CLR_V] && voltage_i <= vfull_q[31:16]);
    empty_set = (flag_cfg_q[B_EMPTY_SET_PCT] && relative_charge_pct_i <= pct_thr_q[23:16])
             || (flag_cfg_q[B_EMPTY_SET_V] && voltage_i <= vempty_q[15:0]);
    empty_clr = (flag_cfg_q[B_EMPTY_CLR_PCT] && relative_charge_pct_i >= pct_thr_q[31:24])
             || (flag_cfg_q[B_EMPTY_CLR_V] && voltage_i >= vempty_q[31:16]);
  end

  // A set condition wins over a clear met in the same sample, so an
  // overlapping threshold setup cannot hide the event.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      full_q  <= 1'b0;
      empty_q <= 1'b0;
    end else if (meas_valid_i) begin
      if (full_set) begin
        full_q <= 1'b1;
      end else if (full_clr) begin
        full_q <= 1'b0;
      end
      if (empty_set) begin
        empty_q <= 1'b1;
      end else if (empty_clr) begin
        empty_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Low-temperature charge inhibit with hysteresis, signed compare.
  // The limit plus hysteresis sum is 16 bits wide and wraps near the
  // top of the range; keep the pair well inside it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inh_q <= 1'b0;
    end else if (meas_valid_i) begin
      if ($signed(temperature_i) < $signed(temp_cfg_q[15:0])) begin
        inh_q <= 1'b1;
      end else if ($signed(temperature_i) >
                   $signed(temp_cfg_q[15:0]) + $signed(temp_cfg_q[31:16])) begin
        inh_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Learning qualification: opened at discharge start when warm, unless the full flag
  // is required and absent, and lost if the temperature dips.
  logic cold;
  assign cold = $signed(temperature_i) <= $signed(cap_cfg_q[15:0]);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vdq_q <= 1'b0;
    end else if (dsg_start_i) begin
      vdq_q <= !cold && (!gauge_cfg_q[B_NEEDS_FULL] || full_q);
    end else if (meas_valid_i && cold) begin
      vdq_q <= 1'b0;
    end
  end

  // ==========================================================
  // Cycle counting; the count loads once from storage after reset.
  // Limitation: a zero floor with a zero per-cent product counts a cycle
  // on every clock, so software must keep the floor above zero.
  logic [31:0] basis_prod, per_cycle;
  logic [15:0] basis_cap;
  always_comb begin
    basis_cap  = gauge_cfg_q[B_CYCLE_BASIS] ? full_cap_i : cap_cfg_q[31:16];
    basis_prod = (basis_cap * cyc_cfg_q[15:0]) / 32'd100;
    per_cycle  = (basis_prod < {16'h0000, cyc_cfg_q[31:16]}) ?
                 {16'h0000, cyc_cfg_q[31:16]} : basis_prod;
  end
  // Design capacity shares the learning-temperature word's upper half.
  logic [31:0] acc_next;
  assign acc_next = dsg_acc_q + {16'h0000, dsg_delta_i};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_q        <= 1'b1;
      cyc_cnt_q     <= 16'h0000;
      dsg_acc_q     <= 32'h0000_0000;
      cycle_store_o <= 1'b0;
    end else begin
      init_q        <= 1'b0;
      cycle_store_o <= 1'b0;
      if (init_q) begin
        cyc_cnt_q <= stored_cycle_i;
      end else if (acc_next >= per_cycle) begin
        dsg_acc_q     <= acc_next - per_cycle;
        cyc_cnt_q     <= cyc_cnt_q + 16'h0001;
        cycle_store_o <= 1'b1;
      end else begin
        dsg_acc_q <= acc_next;
      end
    end
  end

  // ==========================================================
  // Option decode and threshold selection.
  // Design capacity is the upper half of the capacity word, so the learned
  // cap and the cycle basis agree while B_CYCLE_BASIS is clear; it doubles as the overload limit.
  always_comb begin
    threshold_comp_sel_o         = gauge_cfg_q[B_THR_COMP];
    fixed_lowest_threshold_sel_o = gauge_cfg_q[B_THR_COMP] &&
                                   gauge_cfg_q[B_FIXED_LOWEST];
    charger_type_sel_o           = gauge_cfg_q[B_CHARGER_TYPE];
    smoothing_mode_bit_o         = gauge_cfg_q[B_SMOOTHING];
    skip_self_discharge_o        = gauge_cfg_q[B_SKIP_SELF_DSG];
    end_discharge_thr_zero_o     = fixed01_q[15:0];
    end_discharge_thr_one_o      = fixed01_q[31:16];
    end_discharge_thr_two_o      = fixed2_q;
    eod_detect_en_o              = dsg_current_i <= cap_cfg_q[31:16];
    learned_cap_o                = (gauge_cfg_q[B_CAP_LIMIT] &&
                                    learned_cap_i > cap_cfg_q[31:16] ) ?
                                   cap_cfg_q[31:16] : learned_cap_i;
    remaining_sync_o             = charge_term_i && gauge_cfg_q[B_REMAIN_SYNC];
  end

  assign full_charged_flag_o     = full_q;
  assign fully_discharged_flag_o = empty_q;
  assign charge_inhibit_flag_o   = inh_q;
  assign valid_discharge_qual_o  = vdq_q;
  assign cycle_count_o           = cyc_cnt_q;

  // ==========================================================
  // Checks.
  property p_full_set;
    @(posedge clk_i) disable iff (rst_i) meas_valid_i && full_set |=> full_q;
  endproperty
  a_full_set: assert property (p_full_set) else $error("full flag did not set");
  property p_full_clr;
    @(posedge clk_i) disable iff (rst_i) meas_valid_i && full_clr && !full_set |=> !full_q;
  endproperty
  a_full_clr: assert property (p_full_clr) else $error("full flag did not clear");
  property p_empty_set;
    @(posedge clk_i) disable iff (rst_i) meas_valid_i && empty_set |=> empty_q;
  endproperty
  a_empty_set: assert property (p_empty_set) else $error("empty flag did not set");
  property p_empty_clr;
    @(posedge clk_i) disable iff (rst_i) meas_valid_i && empty_clr && !empty_set |=> !empty_q;
  endproperty
  a_empty_clr: assert property (p_empty_clr) else $error("empty flag did not clear");
  property p_cfg_rst;
    @(posedge clk_i) $past(rst_i) && !rst_i |-> flag_cfg_q == FLAG_CFG_RST;
  endproperty
  a_cfg_rst: assert property (p_cfg_rst) else $error("flag config reset wrong");
  property p_inh_set;
    @(posedge clk_i) disable iff (rst_i)
      meas_valid_i && $signed(temperature_i) < $signed(temp_cfg_q[15:0]) |=> inh_q;
  endproperty
  a_inh_set: assert property (p_inh_set) else $error("inhibit did not set");
  property p_inh_hold;
    @(posedge clk_i) disable iff (rst_i)
      inh_q && !(meas_valid_i && $signed(temperature_i) >
      $signed(temp_cfg_q[15:0]) + $signed(temp_cfg_q[31:16])) |=> inh_q;
  endproperty
  a_inh_hold: assert property (p_inh_hold) else $error("inhibit released early");
  property p_vdq_full;
    @(posedge clk_i) disable iff (rst_i)
      dsg_start_i && gauge_cfg_q[B_NEEDS_FULL] && !full_q |=> !vdq_q;
  endproperty
  a_vdq_full: assert property (p_vdq_full) else $error("learning qualified without full");
  sequence s_cycle_step;
    !rst_i && !init_q && acc_next >= per_cycle;
  endsequence
  property p_cycle;
    @(posedge clk_i) disable iff (rst_i)
      s_cycle_step |=> cycle_store_o && cyc_cnt_q == $past(cyc_cnt_q) + 16'h0001;
  endproperty
  a_cycle: assert property (p_cycle) else $error("cycle count step wrong");
  // ==========================================================
  // Handshake, learning, inhibit, count and hold checks.
  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held past one cycle");
  // A cold sample mid-discharge must drop the qualification at once.
  property p_vdq_cold;
    @(posedge clk_i) disable iff (rst_i) meas_valid_i && cold && !dsg_start_i |=> !vdq_q;
  endproperty
  a_vdq_cold: assert property (p_vdq_cold) else $error("learning kept while cold");
  // Release needs a sample above the limit plus hysteresis, not below the limit.
  property p_inh_rel;
    @(posedge clk_i) disable iff (rst_i)
      meas_valid_i && !($signed(temperature_i) < $signed(temp_cfg_q[15:0])) &&
      $signed(temperature_i) > $signed(temp_cfg_q[15:0]) + $signed(temp_cfg_q[31:16])
      |=> !inh_q;
  endproperty
  a_inh_rel: assert property (p_inh_rel) else $error("inhibit did not release");
  // The count takes the stored value on the first edge after reset.
  property p_cycle_init;
    @(posedge clk_i) disable iff (rst_i) init_q |=> cyc_cnt_q == $past(stored_cycle_i);
  endproperty
  a_cycle_init: assert property (p_cycle_init) else $error("count not loaded");
  // Between samples both flags hold, whatever the thresholds do meanwhile.
  sequence s_no_sample;
    !meas_valid_i;
  endsequence
  property p_flags_hold;
    @(posedge clk_i) disable iff (rst_i) s_no_sample |=> $stable(full_q) && $stable(empty_q);
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flag moved unsampled");
  // With the limit on, the learned value never passes design capacity.
  property p_cap_limit;
    @(posedge clk_i) disable iff (rst_i)
      gauge_cfg_q[B_CAP_LIMIT] |-> learned_cap_o <= cap_cfg_q[31:16];
  endproperty
  a_cap_limit: assert property (p_cap_limit) else $error("learned cap over limit");
endmodule

// ===== verilog/csf_pkg.sv
/*
  Constants for the charge-state flag and gauging configuration block:
  register offsets, field positions, reset values and numeric formats.
  Assumes a classic Wishbone slave with 32-bit data and byte addresses.
*/
// Functional notes
// - Full flag sets at percent >= set level.
// - Full flag clears at percent <= clear level.
// - Full flag sets at voltage >= set threshold.
// - Full flag clears at voltage <= clear threshold.
// - Empty flag sets at percent <= set level.
// - Empty flag sets at voltage <= set threshold.
// - Empty flag clears at voltage >= clear threshold.
// - Flag configuration byte resets to 8C.
// - Learning discharge valid only while full flag set; the code checks the flag at discharge start only.
// - Learned capacity capped at design capacity.
// - Fixed or dynamic lowest threshold when compensated.
// - Charger type selects learning optimisation.
// - Compensation bit selects stored or computed thresholds.
// - Sync remaining to full capacity on termination.
// - Cycle basis: design or full capacity.
// - Per-cycle amount floored at minimum threshold.
// - Below low temperature: inhibit charge, set flag.
// - Release inhibit above low temperature plus hysteresis.
// - Hysteresis defaults to five degrees.
// - Overload current halts end-of-discharge detection.
// - Uncompensated: three stored voltages are thresholds.
// - Learning needs temperature above minimum throughout.
package csf_pkg;
  // ==========================================================
  // Register byte offsets.
  localparam logic [7:0] OFS_FLAG_CFG   = 8'h00;
  localparam logic [7:0] OFS_GAUGE_CFG  = 8'h04;
  localparam logic [7:0] OFS_PCT_THR    = 8'h08;
  localparam logic [7:0] OFS_VFULL_THR  = 8'h0C;
  localparam logic [7:0] OFS_VEMPTY_THR = 8'h10;
  localparam logic [7:0] OFS_FIXED_01   = 8'h14;
  localparam logic [7:0] OFS_FIXED_2    = 8'h18;
  localparam logic [7:0] OFS_TEMP_CFG   = 8'h1C;
  localparam logic [7:0] OFS_CAP_CFG    = 8'h20;
  localparam logic [7:0] OFS_CYCLE_CFG  = 8'h24;
  localparam logic [7:0] OFS_STATUS     = 8'h28;
  localparam logic [7:0] OFS_CYCLE_CNT  = 8'h2C;
  // ==========================================================
  // Flag configuration bit positions.
  localparam int B_EMPTY_SET_V    = 0;
  localparam int B_EMPTY_CLR_V    = 1;
  localparam int B_EMPTY_SET_PCT  = 2;
  localparam int B_EMPTY_CLR_PCT  = 3;
  localparam int B_FULL_SET_V     = 4;
  localparam int B_FULL_CLR_V     = 5;
  localparam int B_FULL_SET_PCT   = 6;
  localparam int B_FULL_CLR_PCT   = 7;
  localparam logic [7:0] FLAG_CFG_RST = 8'h8C;
  // Gauging configuration bit positions.
  localparam int B_CYCLE_BASIS    = 0;
  localparam int B_REMAIN_SYNC    = 1;
  localparam int B_THR_COMP       = 3;
  localparam int B_CHARGER_TYPE   = 4;
  localparam int B_FIXED_LOWEST   = 5;
  localparam int B_CAP_LIMIT      = 8;
  localparam int B_NEEDS_FULL     = 10;
  localparam int B_SKIP_SELF_DSG  = 11;
  localparam int B_SMOOTHING      = 12;
  localparam logic [15:0] GAUGE_CFG_RST  = 16'h182A;
  localparam logic [15:0] GAUGE_CFG_MASK = 16'h1D3B;
  // ==========================================================
  // Threshold reset values; temperatures in signed 0.1 degC.
  localparam logic [7:0]  FULL_SET_PCT_RST   = 8'h64;
  localparam logic [7:0]  FULL_CLR_PCT_RST   = 8'h5F;
  localparam logic [7:0]  EMPTY_SET_PCT_RST  = 8'h00;
  localparam logic [7:0]  EMPTY_CLR_PCT_RST  = 8'h05;
  localparam logic [15:0] VOLT_RST           = 16'h0000;
  localparam logic [15:0] INH_LOW_TEMP_RST   = 16'h0000;
  localparam logic [15:0] TEMP_HYS_RST       = 16'h0032;
  localparam logic [15:0] LEARN_TEMP_RST     = 16'h0000;
  localparam logic [15:0] OVERLOAD_RST       = 16'hFFFF;
  localparam logic [15:0] DESIGN_CAP_RST     = 16'h0BB8;
  localparam logic [15:0] CYCLE_PCT_RST      = 16'h005A;
  localparam logic [15:0] CYCLE_MIN_RST      = 16'h0064;
endpackage
